// [shared/mes_pkg.sv]
// constants and carrier types of the metering engine status and configuration bank
package mes_pkg;

    // ****************************************
    // word addresses in engine data memory
    // ****************************************
    localparam logic [9:0] ADDR_IA = 10'h000;
    localparam logic [9:0] ADDR_VA = 10'h001;
    localparam logic [9:0] ADDR_IB = 10'h002;
    localparam logic [9:0] ADDR_VB = 10'h003;
    localparam logic [9:0] ADDR_IC = 10'h004;
    localparam logic [9:0] ADDR_VC = 10'h005;
    localparam logic [9:0] ADDR_ID = 10'h006;
    localparam logic [9:0] ADDR_TEMP = 10'h00A;
    localparam logic [9:0] ADDR_VBAT = 10'h00B;
    localparam logic [9:0] ADDR_PART_REV = 10'h00F;
    localparam logic [9:0] ADDR_CONFIG = 10'h020;
    localparam logic [9:0] ADDR_SAG_THRESHOLD = 10'h024;
    localparam logic [9:0] ADDR_GAIN_ADJUST = 10'h040;
    localparam logic [9:0] ADDR_STATUS = 10'h080;

    // ****************************************
    // sample channels
    // ****************************************
    localparam int NUM_CH = 9;
    localparam int CH_TEMP = 7;
    localparam logic [NUM_CH-1:0][9:0] SAMPLE_ADDRS = {ADDR_VBAT, ADDR_TEMP, ADDR_ID, ADDR_VC, ADDR_IC,
                                                       ADDR_VB, ADDR_IB, ADDR_VA, ADDR_IA};
    localparam logic [2:0][3:0] CURRENT_CH = {4'h4, 4'h2, 4'h0};
    localparam logic [2:0][3:0] VOLTAGE_CH = {4'h5, 4'h3, 4'h1};
    localparam int SHUNT_GAIN_SHIFT = 3;

    // ****************************************
    // configuration word fields and reset
    // ****************************************
    localparam logic [31:0] CFG_RESET = 32'h0000_5020;
    localparam int CFG_SHUNT_LSB = 0;
    localparam int CFG_PULSE_SRC_BIT = 4;
    localparam int CFG_PHASE_SEL_LSB = 6;
    localparam int CFG_SAG_SAMPLE_COUNT_LSB = 8;
    localparam int CFG_TEMP_SRC_BIT = 16;
    localparam int CFG_SAG_INT_BIT = 17;
    localparam int CFG_SAG_EN_LSB = 18;

    // ****************************************
    // status word fields
    // ****************************************
    localparam int STAT_SAG_LSB = 25;
    localparam int STAT_SQUARE_BIT = 28;

    // ****************************************
    // temperature compensation arithmetic
    // ****************************************
    localparam logic signed [31:0] GAIN_NOMINAL = 32'sh0000_4000;
    localparam int LIN_SHIFT = 14;
    localparam int QUAD_SHIFT = 23;

    typedef struct packed {
        logic [9:0] addr;
        logic wrEn;
        logic rdEn;
        logic [31:0] wrData;
    } mes_host_req_t;

    typedef struct packed {
        logic [NUM_CH-1:0][31:0] word;
    } mes_samples_t;

    typedef struct packed {
        logic frameDone;
        logic passDone;
        logic [31:0] hostRealRate;
        logic [31:0] hostReactiveRate;
        logic [31:0] realEnergySum;
        logic [31:0] reactiveEnergySum;
        logic signed [15:0] linearTempCoeff;
        logic signed [15:0] quadraticTempCoeff;
        logic [31:0] tempNominal;
    } mes_engine_in_t;

    typedef struct packed {
        logic [2:0][31:0] currentScaled;
        logic [31:0] realPulseRate;
        logic [31:0] reactivePulseRate;
        logic [31:0] gainAdjust;
        logic [1:0] pllPhaseSel;
        logic fundamentalSquareWave;
        logic secondPulseOutput;
    } mes_engine_out_t;

endpackage : mes_pkg

// [src/mes_sag_detector.sv]
// per-phase sag detector: consecutive below-threshold sample counter
`timescale 1ns/100ps
module mes_sag_detector (
    // clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // sample stream
    input wire logic sampleStrobe,
    input wire logic [31:0] voltageSample,
    // settings
    input wire logic enable,
    input wire logic [31:0] threshold,
    input wire logic [7:0] sampleCount,
    // result
    output logic inSag
);

    typedef struct packed {
        logic [7:0] cnt;
        logic inSag;
    } mes_sag_state_t;

    mes_sag_state_t s_r;
    mes_sag_state_t s_nxt;
    logic [31:0] magnitude;
    logic below;
    logic above;

    assign magnitude = voltageSample[31] ? (~voltageSample + 32'h0000_0001) : voltageSample;
    assign below = magnitude < threshold;
    assign above = magnitude > threshold;
    assign inSag = s_r.inSag;

    always_comb begin
        s_nxt = s_r;
        if (!enable) begin
            s_nxt = '0;
        end else if (sampleStrobe) begin
            if (below) begin
                // saturate so a long sag cannot wrap the count
                if (s_r.cnt != 8'hFF) begin
                    s_nxt.cnt = s_r.cnt + 8'h01;
                end
                if ({1'b0, s_r.cnt} + 9'h001 >= {1'b0, sampleCount}) begin
                    s_nxt.inSag = 1'b1;
                end
            end else begin
                s_nxt.cnt = 8'h00;
                if (above) begin
                    s_nxt.inSag = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    property p_sag_clear;
        @(posedge clk_sys) disable iff (srst)
        (enable && sampleStrobe && above) |=> !inSag;
    endproperty
    a_sag_clear: assert property (p_sag_clear) else $error("sag flag stayed set above threshold");

    property p_sag_disabled;
        @(posedge clk_sys) disable iff (srst)
        !enable |=> !inSag;
    endproperty
    a_sag_disabled: assert property (p_sag_disabled) else $error("sag flag set while disabled");

    property p_sag_cause;
        @(posedge clk_sys) disable iff (srst)
        $rose(inSag) |-> $past(enable) && $past(sampleStrobe) && $past(below)
            && ({1'b0, $past(s_r.cnt)} + 9'h001 >= {1'b0, $past(sampleCount)});
    endproperty
    a_sag_cause: assert property (p_sag_cause) else $error("sag flag set without enough samples");

endmodule : mes_sag_detector

// [src/mes_status_config.sv]
// metering engine raw sample, status and configuration word bank
//
// How it works
// - filtered samples are captured per frame and read at fixed word addresses.
// - identification word reads zero upper half, part code, then revision.
// - status word is rewritten at every pass-done event.
// - sag flags come fresh from detectors each pass, nothing latched.
// - unused status bits 31:29 and 24:0 always read zero.
// - status bit 28 follows the selected phase voltage polarity.
// - sag flag sets after enough low samples, clears above threshold or when the phase is disabled.
// - status word lives at engine word address 0x80.
// - sag detection runs only for phases whose enable bit is one.
// - with sag signalling enabled, a sag event toggles the second pulse output.
// - shunt gain select multiplies that current sample by eight.
// - pulse rates come from host words or own energy sums.
// - internal temperature source makes the engine compute the gain adjust.
// - external temperature source freezes engine updates; host writes gain adjust.
// - frequency-tracking phase follows the two phase-select bits.
// - sag sample count sits in bits 15:8, consecutive low samples counted.
// - sag enables in bits 20:18; event needs every enabled phase sagging.
// - bits 7:6 select phase; 00 is phase A.
`timescale 1ns/100ps
module mes_status_config #(
    // arbitrary identification values
    parameter logic [7:0] PART_CODE = 8'h5A,
    parameter logic [7:0] REVISION = 8'h01
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // host word access
    input wire mes_pkg::mes_host_req_t hostReq,
    output logic [31:0] hostRdData,
    output logic hostRdValid,
    // converter and engine side
    input wire mes_pkg::mes_samples_t samplesIn,
    input wire mes_pkg::mes_engine_in_t engIn,
    output mes_pkg::mes_engine_out_t engOut
);

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        mes_pkg::mes_samples_t samples;
        logic [31:0] cfg;
        logic [31:0] sagThreshold;
        logic [31:0] status;
        logic [31:0] rdData;
        logic rdValid;
        logic sagEventPrev;
        mes_pkg::mes_engine_out_t out;
    } mes_bank_state_t;

    mes_bank_state_t s_r;
    mes_bank_state_t s_nxt;

    logic [2:0] sagFlags;
    logic [2:0] sagEnable;
    logic [1:0] phaseSel;
    logic [1:0] selPhase;
    logic [31:0] selVoltage;
    logic sagEvent;
    logic sagSignal;
    logic tempSrc;
    logic signed [15:0] tempDelta;
    logic signed [31:0] tempDeltaSq;
    logic signed [31:0] linProd;
    logic signed [47:0] quadProd;
    logic signed [31:0] gainCalc;
    logic [31:0] rdWord;

    assign hostRdData = s_r.rdData;
    assign hostRdValid = s_r.rdValid;
    assign engOut = s_r.out;

    // ****************************************
    // configuration decode
    // ****************************************
    assign sagEnable = s_r.cfg[mes_pkg::CFG_SAG_EN_LSB +: 3];
    assign phaseSel = s_r.cfg[mes_pkg::CFG_PHASE_SEL_LSB +: 2];
    assign sagSignal = s_r.cfg[mes_pkg::CFG_SAG_INT_BIT];
    assign tempSrc = s_r.cfg[mes_pkg::CFG_TEMP_SRC_BIT];
    // code 11 has no phase of its own; it falls back to phase C
    assign selPhase = (phaseSel == 2'h3) ? 2'h2 : phaseSel;
    assign selVoltage = s_r.samples.word[mes_pkg::VOLTAGE_CH[selPhase]];

    // ****************************************
    // sag detectors, one per phase
    // ****************************************
    genvar gp;
    generate
        for (gp = 0; gp < 3; gp++) begin : g_sag
            mes_sag_detector u_sag (
                .clk_sys(clk_sys),
                .srst(srst),
                .sampleStrobe(engIn.frameDone),
                .voltageSample(samplesIn.word[mes_pkg::VOLTAGE_CH[gp]]),
                .enable(sagEnable[gp]),
                .threshold(s_r.sagThreshold),
                .sampleCount(s_r.cfg[mes_pkg::CFG_SAG_SAMPLE_COUNT_LSB +: 8]),
                .inSag(sagFlags[gp])
            );
        end
    endgenerate

    // disabled phases do not veto; at least one must be enabled
    assign sagEvent = (|sagEnable) && (&(sagFlags | ~sagEnable));

    // ****************************************
    // temperature compensation
    // ****************************************
    // only the low 16 bits of the difference are used; wider swings wrap
    assign tempDelta = 16'(s_r.samples.word[mes_pkg::CH_TEMP] - engIn.tempNominal);
    assign tempDeltaSq = tempDelta * tempDelta;
    assign linProd = engIn.linearTempCoeff * tempDelta;
    assign quadProd = engIn.quadraticTempCoeff * tempDeltaSq;
    assign gainCalc = mes_pkg::GAIN_NOMINAL + (linProd >>> mes_pkg::LIN_SHIFT)
        + 32'(quadProd >>> mes_pkg::QUAD_SHIFT);

    // ****************************************
    // read decode
    // ****************************************
    always_comb begin
        rdWord = 32'h0000_0000;
        for (int i = 0; i < mes_pkg::NUM_CH; i++) begin
            if (hostReq.addr == mes_pkg::SAMPLE_ADDRS[i]) begin
                rdWord = s_r.samples.word[i];
            end
        end
        if (hostReq.addr == mes_pkg::ADDR_PART_REV) begin
            rdWord = {16'h0000, PART_CODE, REVISION};
        end else if (hostReq.addr == mes_pkg::ADDR_CONFIG) begin
            rdWord = s_r.cfg;
        end else if (hostReq.addr == mes_pkg::ADDR_SAG_THRESHOLD) begin
            rdWord = s_r.sagThreshold;
        end else if (hostReq.addr == mes_pkg::ADDR_GAIN_ADJUST) begin
            rdWord = s_r.out.gainAdjust;
        end else if (hostReq.addr == mes_pkg::ADDR_STATUS) begin
            rdWord = s_r.status;
        end
    end

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        s_nxt = s_r;
        s_nxt.rdValid = hostReq.rdEn;
        if (hostReq.rdEn) begin
            s_nxt.rdData = rdWord;
        end

        // host writes; read-only and unmapped words ignore them
        if (hostReq.wrEn) begin
            if (hostReq.addr == mes_pkg::ADDR_CONFIG) begin
                s_nxt.cfg = hostReq.wrData;
            end else if (hostReq.addr == mes_pkg::ADDR_SAG_THRESHOLD) begin
                s_nxt.sagThreshold = hostReq.wrData;
            end else if (hostReq.addr == mes_pkg::ADDR_GAIN_ADJUST) begin
                s_nxt.out.gainAdjust = hostReq.wrData;
            end
        end

        if (engIn.frameDone) begin
            s_nxt.samples = samplesIn;
            for (int p = 0; p < 3; p++) begin
                if (s_r.cfg[mes_pkg::CFG_SHUNT_LSB + p]) begin
                    s_nxt.out.currentScaled[p] = samplesIn.word[mes_pkg::CURRENT_CH[p]]
                        << mes_pkg::SHUNT_GAIN_SHIFT;
                end else begin
                    s_nxt.out.currentScaled[p] = samplesIn.word[mes_pkg::CURRENT_CH[p]];
                end
            end
        end

        if (engIn.passDone) begin
            s_nxt.status = 32'h0000_0000;
            s_nxt.status[mes_pkg::STAT_SAG_LSB +: 3] = sagFlags;
            s_nxt.status[mes_pkg::STAT_SQUARE_BIT] = ~selVoltage[31];
            s_nxt.out.fundamentalSquareWave = ~selVoltage[31];
            if (s_r.cfg[mes_pkg::CFG_PULSE_SRC_BIT]) begin
                s_nxt.out.realPulseRate = engIn.hostRealRate;
                s_nxt.out.reactivePulseRate = engIn.hostReactiveRate;
            end else begin
                s_nxt.out.realPulseRate = engIn.realEnergySum;
                s_nxt.out.reactivePulseRate = engIn.reactiveEnergySum;
            end
            // engine update wins over a host write landing in the same cycle
            if (!tempSrc) begin
                s_nxt.out.gainAdjust = gainCalc;
            end
        end

        s_nxt.out.pllPhaseSel = phaseSel;
        s_nxt.sagEventPrev = sagEvent;
        if (sagSignal && sagEvent && !s_r.sagEventPrev) begin
            s_nxt.out.secondPulseOutput = ~s_r.out.secondPulseOutput;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            s_r <= '0;
            s_r.cfg <= mes_pkg::CFG_RESET;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    sequence s_sag_rise;
        sagSignal && sagEvent && !s_r.sagEventPrev;
    endsequence

    property p_sag_toggle;
        @(posedge clk_sys) disable iff (srst)
        s_sag_rise |=> (engOut.secondPulseOutput != $past(engOut.secondPulseOutput));
    endproperty
    a_sag_toggle: assert property (p_sag_toggle) else $error("sag event did not toggle pulse output");

    property p_sag_quiet;
        @(posedge clk_sys) disable iff (srst)
        !sagSignal |=> $stable(engOut.secondPulseOutput);
    endproperty
    a_sag_quiet: assert property (p_sag_quiet) else $error("pulse output moved with signalling off");

    property p_sag_all;
        @(posedge clk_sys) disable iff (srst)
        (sagSignal && (sagEnable == 3'h3) && !(sagFlags[0] && sagFlags[1]))[*2] |=> $stable(engOut.secondPulseOutput);
    endproperty
    a_sag_all: assert property (p_sag_all) else $error("sag event without all enabled phases");

    property p_status_fill;
        @(posedge clk_sys) disable iff (srst)
        engIn.passDone |=> (s_r.status[27:25] == $past(sagFlags))
            && (s_r.status[28] == !$past(selVoltage[31]));
    endproperty
    a_status_fill: assert property (p_status_fill) else $error("status not refreshed at pass done");

    property p_status_hold;
        @(posedge clk_sys) disable iff (srst)
        !engIn.passDone |=> $stable(s_r.status);
    endproperty
    a_status_hold: assert property (p_status_hold) else $error("status changed between passes");

    property p_status_zero;
        @(posedge clk_sys) disable iff (srst)
        (s_r.status[31:29] == 3'h0) && (s_r.status[24:0] == 25'h0000000);
    endproperty
    a_status_zero: assert property (p_status_zero) else $error("unused status bits not zero");

    property p_status_read;
        @(posedge clk_sys) disable iff (srst)
        (hostReq.rdEn && hostReq.addr == mes_pkg::ADDR_STATUS) |=> hostRdValid && (hostRdData == $past(s_r.status));
    endproperty
    a_status_read: assert property (p_status_read) else $error("status read wrong");

    property p_id_read;
        @(posedge clk_sys) disable iff (srst)
        (hostReq.rdEn && hostReq.addr == mes_pkg::ADDR_PART_REV) |=> (hostRdData == {16'h0000, PART_CODE, REVISION});
    endproperty
    a_id_read: assert property (p_id_read) else $error("identification word wrong");

    property p_sample_read;
        @(posedge clk_sys) disable iff (srst)
        (engIn.frameDone ##1 (hostReq.rdEn && hostReq.addr == mes_pkg::ADDR_VBAT && !engIn.frameDone))
            |=> (hostRdData == $past(samplesIn.word[8], 2));
    endproperty
    a_sample_read: assert property (p_sample_read) else $error("sample word not captured");

    property p_shunt;
        @(posedge clk_sys) disable iff (srst)
        (engIn.frameDone && s_r.cfg[mes_pkg::CFG_SHUNT_LSB]) |=>
            (engOut.currentScaled[0] == {$past(samplesIn.word[0][28:0]), 3'h0});
    endproperty
    a_shunt: assert property (p_shunt) else $error("shunt gain not applied");

    property p_rate_host;
        @(posedge clk_sys) disable iff (srst)
        (engIn.passDone && s_r.cfg[mes_pkg::CFG_PULSE_SRC_BIT]) |=> (engOut.realPulseRate == $past(engIn.hostRealRate));
    endproperty
    a_rate_host: assert property (p_rate_host) else $error("host pulse rate not used");

    property p_gain_internal;
        @(posedge clk_sys) disable iff (srst)
        (engIn.passDone && !tempSrc) |=> (engOut.gainAdjust == $past(gainCalc));
    endproperty
    a_gain_internal: assert property (p_gain_internal) else $error("gain adjust not computed");

    property p_gain_external;
        @(posedge clk_sys) disable iff (srst)
        (tempSrc && !(hostReq.wrEn && hostReq.addr == mes_pkg::ADDR_GAIN_ADJUST)) |=> $stable(engOut.gainAdjust);
    endproperty
    a_gain_external: assert property (p_gain_external) else $error("engine touched host gain adjust");

    property p_pll_sel;
        @(posedge clk_sys) disable iff (srst)
        ##1 (engOut.pllPhaseSel == $past(phaseSel));
    endproperty
    a_pll_sel: assert property (p_pll_sel) else $error("tracking phase not following select");

endmodule : mes_status_config

// [tb/mes_host_model.sv]
// host processor model that reaches the engine words one at a time
`timescale 1ns/100ps
module mes_host_model (
    // clock
    input wire logic clk_sys,
    // host word access
    output mes_pkg::mes_host_req_t hostReq,
    input wire logic [31:0] hostRdData,
    input wire logic hostRdValid
);
    // ****************************************
    // word access tasks
    // ****************************************
    initial hostReq = '0;

    // configuration and gain-adjust words are written here by the host
    task automatic wr(input logic [9:0] a, input logic [31:0] dat);
        @(posedge clk_sys);
        hostReq.addr <= a;
        hostReq.wrData <= dat;
        hostReq.wrEn <= 1'b1;
        @(posedge clk_sys);
        hostReq.wrEn <= 1'b0;
        // released lines must not keep showing the last value
        hostReq.addr <= ~a;
        hostReq.wrData <= ~dat;
    endtask : wr

    task automatic rd(input logic [9:0] a, output logic [31:0] dat);
        @(posedge clk_sys);
        hostReq.addr <= a;
        hostReq.rdEn <= 1'b1;
        @(posedge clk_sys);
        hostReq.rdEn <= 1'b0;
        hostReq.addr <= ~a;
        @(negedge clk_sys);
        dat = (hostRdValid === 1'b1) ? hostRdData : 'x;
    endtask : rd
endmodule : mes_host_model

// [tb/testbench.sv]
// self-checking bench of the metering engine status and configuration bank
`timescale 1ns/100ps
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin err_total++; \
    $display("wrong value at %0t: got %h expected %h", $time, (got), (exp)); end end
module testbench;
    logic clk_sys;
    logic srst;
    mes_pkg::mes_host_req_t hostReq;
    logic [31:0] hostRdData;
    logic hostRdValid;
    mes_pkg::mes_samples_t samplesIn;
    mes_pkg::mes_engine_in_t engIn;
    mes_pkg::mes_engine_out_t engOut;
    int err_total = 0;
    int n_compared = 0;
    logic [31:0] d;
    logic [31:0] g;
    logic [31:0] va;
    logic [2:0] sh;
    logic sq;
    logic [15:0] tdel;
    logic spo;
    // arbitrary identification values
    localparam logic [7:0] PART = 8'h3C;
    localparam logic [7:0] REV = 8'h07;

    mes_status_config #(.PART_CODE(PART), .REVISION(REV)) dut (.clk_sys(clk_sys), .srst(srst), .hostReq(hostReq),
        .hostRdData(hostRdData), .hostRdValid(hostRdValid), .samplesIn(samplesIn), .engIn(engIn), .engOut(engOut));
    mes_host_model host (.clk_sys(clk_sys), .hostReq(hostReq), .hostRdData(hostRdData), .hostRdValid(hostRdValid));

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [31:0] cfgWord(logic [2:0] en, logic sagInt, logic tmp, logic [7:0] cnt,
        logic [1:0] sel, logic src, logic [2:0] shunt);
        return {11'h000, en, sagInt, tmp, cnt, sel, 1'b0, src, 1'b0, shunt};
    endfunction : cfgWord

    function automatic logic [31:0] statWord(logic sq, logic [2:0] sag);
        return {3'b000, sq, sag, 25'h0000000};
    endfunction : statWord

    // gain adjust: nominal plus linear and quadratic temperature terms
    function automatic logic [31:0] gainExp(logic signed [15:0] lin, logic signed [15:0] quad, logic signed [15:0] dt);
        logic signed [47:0] l;
        logic signed [47:0] q;
        l = lin * dt;
        q = quad * dt * dt;
        return 32'(48'sh4000 + (l >>> 14) + (q >>> 23));
    endfunction : gainExp

    // magnitude below the 0x1000 threshold, or clearly above it, with random sign
    function automatic logic [31:0] volt(input logic big);
        logic [31:0] m;
        m = big ? 32'h0000_1001 + ($urandom() % 32'h0001_0000) : $urandom() % 32'h0000_1000;
        return ($urandom() % 2) ? -m : m;
    endfunction : volt

    task automatic pulse(input logic frame, input logic pass);
        @(posedge clk_sys);
        engIn.frameDone <= frame;
        engIn.passDone <= pass;
        @(posedge clk_sys);
        engIn.frameDone <= 1'b0;
        engIn.passDone <= 1'b0;
        @(negedge clk_sys);
    endtask : pulse

    task automatic frameV(input logic [31:0] a, input logic [31:0] b);
        @(posedge clk_sys);
        samplesIn.word[1] <= a;
        samplesIn.word[3] <= b;
        va = a;
        pulse(1'b1, 1'b0);
    endtask : frameV

    task automatic sagCheck(input logic [2:0] sag, input logic toggled);
        pulse(1'b0, 1'b1);
        host.rd(mes_pkg::ADDR_STATUS, d);
        `CHK(d, statWord(~va[31], sag))
        `CHK(engOut.secondPulseOutput, spo ^ toggled)
        spo = spo ^ toggled;
    endtask : sagCheck

    task automatic done(input string name);
        $display("test %s finished", name);
    endtask : done

    task automatic end_of_test();
        $display("comparisons %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : end_of_test

    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    // the tests take a few hundred cycles; twenty thousand means a hang
    initial begin
        #2_000_000;
        err_total++;
        end_of_test();
    end

    // ****************************************
    // tests
    // ****************************************
    initial begin
        srst = 1'b1;
        samplesIn = '0;
        engIn = '0;
        spo = 1'b0;
        void'($urandom(32'h19D5));
        repeat (20) @(posedge clk_sys);
        srst <= 1'b0;
        @(negedge clk_sys);
        `CHK(engOut, '0)
        host.rd(mes_pkg::ADDR_CONFIG, d);
        `CHK(d, 32'h0000_5020)
        host.rd(mes_pkg::ADDR_STATUS, d);
        `CHK(d, 32'h0000_0000)
        host.rd(10'h3FF, d);
        `CHK(d, 32'h0000_0000)
        done("reset");
        host.wr(mes_pkg::ADDR_PART_REV, $urandom());
        host.rd(mes_pkg::ADDR_PART_REV, d);
        `CHK(d, {16'h0000, PART, REV})
        @(posedge clk_sys);
        for (int i = 0; i < 9; i++) samplesIn.word[i] <= $urandom();
        pulse(1'b1, 1'b0);
        host.wr(mes_pkg::ADDR_VA, ~samplesIn.word[1]);
        for (int i = 0; i < 9; i++) begin
            host.rd(mes_pkg::SAMPLE_ADDRS[i], d);
            `CHK(d, samplesIn.word[i])
        end
        done("samples");
        for (int s = 0; s < 4; s++) begin
            host.wr(mes_pkg::ADDR_CONFIG, cfgWord(3'b000, 1'b0, 1'b0, 8'h00, s[1:0], 1'b0, 3'b000));
            @(posedge clk_sys);
            for (int k = 0; k < 3; k++) samplesIn.word[mes_pkg::VOLTAGE_CH[k]] <= $urandom();
            pulse(1'b1, 1'b0);
            pulse(1'b0, 1'b1);
            d = samplesIn.word[mes_pkg::VOLTAGE_CH[(s == 3) ? 2 : s]];
            sq = ~d[31];
            `CHK(engOut.fundamentalSquareWave, sq)
            `CHK(engOut.pllPhaseSel, s[1:0])
            host.rd(mes_pkg::ADDR_STATUS, d);
            `CHK(d, statWord(sq, 3'b000))
        end
        done("phase select");
        for (int s = 0; s < 2; s++) begin
            sh = {s[0], ~s[0], s[0]};
            // shunt bits change here; pulse weight is outside this bank
            host.wr(mes_pkg::ADDR_CONFIG, cfgWord(3'b000, 1'b0, 1'b0, 8'h00, 2'b00, s[0], sh));
            @(posedge clk_sys);
            for (int k = 0; k < 9; k++) samplesIn.word[k] <= $urandom();
            engIn.hostRealRate <= $urandom();
            engIn.hostReactiveRate <= $urandom();
            engIn.realEnergySum <= $urandom();
            engIn.reactiveEnergySum <= $urandom();
            pulse(1'b1, 1'b1);
            for (int k = 0; k < 3; k++) begin
                d = samplesIn.word[mes_pkg::CURRENT_CH[k]];
                `CHK(engOut.currentScaled[k], sh[k] ? {d[28:0], 3'b000} : d)
            end
            `CHK(engOut.realPulseRate, s ? engIn.hostRealRate : engIn.realEnergySum)
            `CHK(engOut.reactivePulseRate, s ? engIn.hostReactiveRate : engIn.reactiveEnergySum)
        end
        done("shunt and pulse source");
        host.wr(mes_pkg::ADDR_CONFIG, cfgWord(3'b000, 1'b0, 1'b1, 8'h00, 2'b00, 1'b0, 3'b000));
        g = $urandom();
        host.wr(mes_pkg::ADDR_GAIN_ADJUST, g);
        pulse(1'b0, 1'b1);
        host.rd(mes_pkg::ADDR_GAIN_ADJUST, d);
        `CHK(d, g)
        host.wr(mes_pkg::ADDR_CONFIG, cfgWord(3'b000, 1'b0, 1'b0, 8'h00, 2'b00, 1'b0, 3'b000));
        @(posedge clk_sys);
        engIn.linearTempCoeff <= 16'($urandom());
        engIn.quadraticTempCoeff <= 16'($urandom());
        // small positive temperature difference so both terms are exercised
        tdel = 16'($urandom() % 256);
        engIn.tempNominal <= samplesIn.word[mes_pkg::CH_TEMP] - {16'h0000, tdel};
        pulse(1'b0, 1'b1);
        `CHK(engOut.gainAdjust, gainExp(engIn.linearTempCoeff, engIn.quadraticTempCoeff, tdel))
        done("temperature compensation");
        host.wr(mes_pkg::ADDR_SAG_THRESHOLD, 32'h0000_1000);
        // sags are signalled on the pulse output as well as read back from the status word
        host.wr(mes_pkg::ADDR_CONFIG, cfgWord(3'b011, 1'b1, 1'b0, 8'h03, 2'b00, 1'b0, 3'b000));
        repeat (2) frameV(volt(1'b0), volt(1'b1));
        sagCheck(3'b000, 1'b0);
        frameV(volt(1'b0), volt(1'b1));
        sagCheck(3'b001, 1'b0);
        repeat (3) frameV(volt(1'b0), volt(1'b0));
        sagCheck(3'b011, 1'b1);
        frameV(volt(1'b1), volt(1'b0));
        sagCheck(3'b010, 1'b0);
        host.wr(mes_pkg::ADDR_CONFIG, cfgWord(3'b010, 1'b0, 1'b0, 8'h03, 2'b00, 1'b0, 3'b000));
        repeat (3) frameV(volt(1'b0), volt(1'b0));
        sagCheck(3'b010, 1'b0);
        @(posedge clk_sys);
        samplesIn.word[5] <= volt(1'b0);
        // count of one: the first low sample already raises the phase A and C flags; phase B stays set
        host.wr(mes_pkg::ADDR_CONFIG, cfgWord(3'b111, 1'b1, 1'b0, 8'h01, 2'b00, 1'b0, 3'b000));
        frameV(volt(1'b0), volt(1'b0));
        sagCheck(3'b111, 1'b1);
        done("sag");
        end_of_test();
    end
endmodule : testbench
